// >>> hw/pcag_channel.v
// Purpose: one pulse output channel with busy, stop and count
// Assumes: start only while idle; guard lives in top
// Notes:   deceleration cuts rate to one fifth for a tail of up to 16 pulses, shorter if the count runs out
`timescale 1ns/10ps
`include "pcag_regs.vh"
module pcag_channel (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        tick,
	input  wire        start,
	input  wire        run_level,
	input  wire        limit_hit,
	input  wire        stop_now,
	input  wire [31:0] target,
	input  wire        dir,
	input  wire        count_pos,
	output reg         pulse,
	output reg         busy,
	output reg  [31:0] position,
	output reg  [31:0] emitted
);
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN  = 3'b010;
	localparam ST_DEC  = 3'b100;

	reg [2:0]  state_reg;
	reg [31:0] left_reg;
	reg [15:0] tail_reg;
	reg [7:0]  slow_reg;
	reg        dir_reg;
	wire       step_ok;
	wire       edge_done;

	assign step_ok   = tick && (state_reg != ST_DEC || slow_reg == 8'h00);
	assign edge_done = step_ok && pulse;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			left_reg  <= 32'h0000_0000;
			tail_reg  <= 16'h0000;
			slow_reg  <= 8'h00;
			dir_reg   <= 1'b0;
			pulse     <= 1'b0;
			busy      <= 1'b0;
			position  <= 32'h0000_0000;
			emitted   <= 32'h0000_0000;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				pulse <= 1'b0;
				if (start && target != 32'h0000_0000) begin
					state_reg <= ST_RUN;
					left_reg  <= target;
					dir_reg   <= dir;
					busy      <= 1'b1; // R15
					emitted   <= 32'h0000_0000;
				end
			end
			ST_RUN: begin
				if (stop_now) begin
					state_reg <= ST_IDLE; // R12
					pulse     <= 1'b0;
					busy      <= 1'b0;
				end else if (!run_level || limit_hit) begin
					state_reg <= ST_DEC; // R11
					tail_reg  <= `PCAG_DECEL_PULSES;
					slow_reg  <= `PCAG_DECEL_SLOW;
				end else if (step_ok) begin
					pulse <= ~pulse;
					if (edge_done) begin
						emitted  <= emitted + 32'h0000_0001;
						// Legacy pulses stay out of the positioning count
						if (count_pos)
							position <= dir_reg ? position - 32'h0000_0001
							                    : position + 32'h0000_0001; // R8
						left_reg <= left_reg - 32'h0000_0001;
						if (left_reg == 32'h0000_0001) begin
							state_reg <= ST_IDLE;
							busy      <= 1'b0; // R15
						end
					end
				end
			end
			ST_DEC: begin
				if (tick)
					slow_reg <= (slow_reg == 8'h00) ? `PCAG_DECEL_SLOW : slow_reg - 8'h01;
				if (stop_now) begin
					state_reg <= ST_IDLE; // R12
					pulse     <= 1'b0;
					busy      <= 1'b0;
				end else if (step_ok) begin
					pulse <= ~pulse;
					if (edge_done) begin
						emitted  <= emitted + 32'h0000_0001;
						if (count_pos)
							position <= dir_reg ? position - 32'h0000_0001
							                    : position + 32'h0000_0001; // R8
						left_reg <= left_reg - 32'h0000_0001;
						tail_reg <= tail_reg - 16'h0001;
						if (tail_reg == 16'h0001 || left_reg == 32'h0000_0001) begin
							state_reg <= ST_IDLE;
							busy      <= 1'b0; // R3
						end
					end
				end
			end
			default: begin
				state_reg <= ST_IDLE;
				busy      <= 1'b0;
				pulse     <= 1'b0;
			end
			endcase
		end
	end
endmodule

// >>> hw/pcag_divider.v
// Purpose: pulse-rate enable divider
// Assumes: one clock, synchronous reset copy
// Notes:   tick is one cycle wide
`timescale 1ns/10ps
`include "pcag_regs.vh"
module pcag_divider (
	input  wire                   clk_sys,
	input  wire                   rst_n,
	input  wire [`PCAG_DIVW-1:0]  half_cycles,
	output reg                    tick
);
	reg [`PCAG_DIVW-1:0] cnt_reg;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			tick    <= 1'b0;
		end else if (cnt_reg >= half_cycles - 8'h01) begin
			cnt_reg <= 8'h00;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			tick    <= 1'b0;
		end
	end
endmodule

// >>> hw/pcag_regs.vh
// Purpose: constants for the pulse channel activation guard
// Assumes: 40 MHz clk_sys, one sequence program as commander
// Notes:   PCAG_HALF_CYC in cycles of clk_sys; decel counts in pulses and ticks
`ifndef PCAG_REGS_VH
`define PCAG_REGS_VH

// ----------------------------------------
// Channels and commands
// ----------------------------------------
`define PCAG_NCH              4
`define PCAG_CHW              2
`define PCAG_CMDW             4
`define PCAG_CMD_ZERO_SEARCH  4'h0
`define PCAG_CMD_FIXED_FEED   4'h1
`define PCAG_CMD_TABLE        4'h2
`define PCAG_CMD_ABS_READOUT  4'h3
`define PCAG_CMD_ZERO_PLAIN   4'h4
`define PCAG_CMD_VAR_SPEED    4'h5
`define PCAG_CMD_INCR_DRIVE   4'h6
`define PCAG_CMD_ABS_DRIVE    4'h7
`define PCAG_CMD_FIXED_COUNT  4'h8
`define PCAG_CMD_RAMPED       4'h9

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCAG_CLK_HZ           40000000
`define PCAG_PULSE_HZ         100000
// Clock over pulse rate, halved; sized to the divider port
`define PCAG_HALF_CYC         8'hC8
`define PCAG_DIVW             8
`define PCAG_DECEL_PULSES     16'h0010
`define PCAG_DECEL_SLOW       8'h04
`define PCAG_ABS_TIMEOUT      16'hFFFF

`endif

// >>> hw/pcag_top.v
// What this block does
// (R1) Busy channel refuses non-readout positioning commands
// (R2) Busy flag blocks positioning and legacy commands
// (R3) Busy follows pulses, not command input
// (R4) Program waits one scan after busy clears
// (R5) Program starts readout at servo power-up
// (R6) Readout fetches servo position exactly once
// (R7) Dropping readout switches servo amplifier off
// (R8) Separate 32-bit positioning count per channel
// (R9) Program never shares channel between families
// (R10) Program prefers incremental drive over legacy
// (R11) Normal stop decelerates before ending output
// (R12) Stop flag halts channel output immediately
// (R13) Fourth channel needs two line-driver adapters
// (R14) Program adds backlash pulses on reversal
// (R15) Busy set at start, cleared at end
//
// Purpose: activation guard over four pulse output channels
// Assumes: commands come from logic on clk_sys
// Notes:   register port: addr, wdata, wr, rd, rdata next cycle
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "pcag_regs.vh"
module pcag_top (
	input  wire                  clk_sys,
	input  wire                  nrst,
	input  wire                  cmd_start,
	input  wire [`PCAG_CMDW-1:0] cmd_code,
	input  wire [`PCAG_CHW-1:0]  cmd_channel,
	input  wire [31:0]           cmd_count,
	input  wire                  cmd_dir,
	input  wire [3:0]            cmd_active,
	input  wire [3:0]            limit_fwd,
	input  wire [3:0]            limit_rev,
	input  wire [3:0]            stop_cmd,
	input  wire                  two_adapters,
	input  wire                  servo_pos_valid,
	input  wire [31:0]           servo_pos_data,
	input  wire [3:0]            reg_addr,
	input  wire                  reg_wr,
	input  wire                  reg_rd,
	input  wire [31:0]           reg_wdata,
	output reg  [31:0]           reg_rdata,
	output reg  [3:0]            pulse_out,
	output reg  [3:0]            dir_out,
	output reg  [3:0]            busy_flag,
	output reg                   cmd_refused,
	output reg                   servo_on,
	output reg                   servo_pos_req
);
	// ----------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------
	reg        rst_s1;
	reg        rst_n;
	reg [3:0]  lf_s1, lf_s2, lr_s1, lr_s2, st_s1, st_s2;
	reg        ad_s1, ad_s2, pv_s1, pv_s2;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lf_s1 <= 4'h0; lf_s2 <= 4'h0;
			lr_s1 <= 4'h0; lr_s2 <= 4'h0;
			st_s1 <= 4'h0; st_s2 <= 4'h0;
			ad_s1 <= 1'b0; ad_s2 <= 1'b0;
			pv_s1 <= 1'b0; pv_s2 <= 1'b0;
		end else begin
			lf_s1 <= limit_fwd;  lf_s2 <= lf_s1;
			lr_s1 <= limit_rev;  lr_s2 <= lr_s1;
			st_s1 <= stop_cmd;   st_s2 <= st_s1;
			ad_s1 <= two_adapters; ad_s2 <= ad_s1;
			pv_s1 <= servo_pos_valid; pv_s2 <= pv_s1;
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	function is_legacy;
		input [`PCAG_CMDW-1:0] c;
		begin
			is_legacy = (c == `PCAG_CMD_FIXED_COUNT) || (c == `PCAG_CMD_RAMPED);
		end
	endfunction

	function is_known;
		input [`PCAG_CMDW-1:0] c;
		begin
			is_known = (c <= `PCAG_CMD_RAMPED);
		end
	endfunction

	wire [3:0] busy_w;
	wire [3:0] pulse_w;
	wire [31:0] pos_w [0:3];
	wire [31:0] emit_w [0:3];
	wire       tick;
	wire       want_abs;
	wire       chan_ok;
	wire       start_ok;
	wire [3:0] start_vec;
	reg  [3:0] legacy_reg;
	reg  [3:0] dir_reg;
	reg  [31:0] legacy_cnt_reg [0:1];

	assign want_abs  = cmd_start && cmd_code == `PCAG_CMD_ABS_READOUT;
	assign chan_ok   = (cmd_channel != 2'h3) || ad_s2; // R13
	assign start_ok  = cmd_start && is_known(cmd_code) && !want_abs && chan_ok
	                 && !busy_w[cmd_channel]; // R1 R2
	assign start_vec = start_ok ? (4'h1 << cmd_channel) : 4'h0;

	// ----------------------------------------
	// Pulse rate and channels
	// ----------------------------------------
	pcag_divider u_div (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.half_cycles (`PCAG_HALF_CYC),
		.tick        (tick)
	);

	genvar g;
	generate
		for (g = 0; g < `PCAG_NCH; g = g + 1) begin : gch
			pcag_channel u_ch (
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.tick      (tick),
				.start     (start_vec[g]),
				.run_level (cmd_active[g]),
				.limit_hit (dir_reg[g] ? lr_s2[g] : lf_s2[g]),
				.stop_now  (st_s2[g]),
				.target    (cmd_count),
				.dir       (cmd_dir),
				.count_pos (!legacy_reg[g]), // R8
				.pulse     (pulse_w[g]),
				.busy      (busy_w[g]),
				.position  (pos_w[g]),
				.emitted   (emit_w[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Legacy counters, refusal, outputs
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			legacy_reg        <= 4'h0;
			dir_reg           <= 4'h0;
			legacy_cnt_reg[0] <= 32'h0000_0000;
			legacy_cnt_reg[1] <= 32'h0000_0000;
			cmd_refused       <= 1'b0;
			pulse_out         <= 4'h0;
			dir_out           <= 4'h0;
			busy_flag         <= 4'h0;
		end else begin
			cmd_refused <= cmd_start && !want_abs && !start_ok; // R1
			if (start_ok) begin
				legacy_reg[cmd_channel] <= is_legacy(cmd_code);
				dir_reg[cmd_channel]    <= cmd_dir;
			end
			// Legacy count kept apart, only channels 0 and 1
			// One cycle past busy still copies the final pulse
			if (legacy_reg[0] && (busy_w[0] || busy_flag[0]))
				legacy_cnt_reg[0] <= emit_w[0]; // R8
			if (legacy_reg[1] && (busy_w[1] || busy_flag[1]))
				legacy_cnt_reg[1] <= emit_w[1];
			pulse_out <= pulse_w;
			dir_out   <= dir_reg;
			busy_flag <= busy_w; // R2 R3
		end
	end

	// ----------------------------------------
	// Absolute readout
	// ----------------------------------------
	reg        abs_done_reg;
	reg        abs_run_reg;
	reg [31:0] abs_pos_reg;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			servo_on      <= 1'b0;
			servo_pos_req <= 1'b0;
			abs_done_reg  <= 1'b0;
			abs_run_reg   <= 1'b0;
			abs_pos_reg   <= 32'h0000_0000;
		end else if (want_abs) begin
			abs_run_reg <= 1'b1;
			servo_on    <= 1'b1;
			if (!abs_done_reg && !servo_pos_req)
				servo_pos_req <= 1'b1; // R6
			if (servo_pos_req && pv_s2) begin
				servo_pos_req <= 1'b0;
				abs_done_reg  <= 1'b1; // R6
				abs_pos_reg   <= servo_pos_data;
			end
		end else begin
			if (abs_run_reg)
				servo_on <= 1'b0; // R7
			abs_run_reg   <= 1'b0;
			servo_pos_req <= 1'b0;
			abs_done_reg  <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
			4'h0:    reg_rdata <= pos_w[0];
			4'h1:    reg_rdata <= pos_w[1];
			4'h2:    reg_rdata <= pos_w[2];
			4'h3:    reg_rdata <= ad_s2 ? pos_w[3] : 32'h0000_0000; // R13
			4'h4:    reg_rdata <= legacy_cnt_reg[0];
			4'h5:    reg_rdata <= legacy_cnt_reg[1];
			4'h6:    reg_rdata <= {28'h0000000, busy_w};
			4'h7:    reg_rdata <= abs_pos_reg;
			default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// >>> sim/pcag_servo_model.sv
// Purpose: servo amplifier answering one position fetch
// Assumes: request is a level, answer held until it drops
// Notes:   idle data lines toggle so no stale word looks valid
`timescale 1ns/10ps
module pcag_servo_model #(
	parameter DELAY = 8
) (
	input  wire         clk_sys,
	input  wire         servo_on,
	input  wire         servo_pos_req,
	input  wire  [31:0] value,
	output logic        servo_pos_valid,
	output logic [31:0] servo_pos_data,
	output integer      fetches
);
	integer wait_cnt;
	initial begin
		servo_pos_valid = 1'b0;
		servo_pos_data = 32'h0;
		fetches = 0;
		wait_cnt = 0;
	end
	always @(posedge clk_sys) begin
		if (servo_on && servo_pos_req) begin
			wait_cnt <= wait_cnt + 1;
			// Counter runs past DELAY, so one answer per request
			if (wait_cnt == DELAY) begin
				servo_pos_valid <= 1'b1;
				servo_pos_data <= value;
				fetches <= fetches + 1;
			end
		end else begin
			wait_cnt <= 0;
			servo_pos_valid <= 1'b0;
			servo_pos_data <= ~servo_pos_data;
		end
	end
endmodule

// >>> sim/pcag_top_checker.sv
// Purpose: port-level timing checks of the activation guard
// Assumes: one clock, nrst async active low
// Notes:   bound into pcag_top
`timescale 1ns/10ps
module pcag_top_checker (
	input wire       clk_sys,
	input wire       nrst,
	input wire       cmd_start,
	input wire [3:0] cmd_code,
	input wire [1:0] cmd_channel,
	input wire [3:0] cmd_active,
	input wire [3:0] stop_cmd,
	input wire       two_adapters,
	input wire [3:0] pulse_out,
	input wire [3:0] busy_flag,
	input wire       cmd_refused,
	input wire       servo_on,
	input wire       servo_pos_req
);
	logic fetched_reg;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			fetched_reg <= 1'b0;
		else if (!servo_on)
			fetched_reg <= 1'b0;
		else if ($fell(servo_pos_req))
			fetched_reg <= 1'b1;
	end
	a_refuse_busy: assert property (cmd_start && cmd_code != 4'h3 && busy_flag[cmd_channel]
		##1 busy_flag[$past(cmd_channel)] |-> cmd_refused) else $error("busy start taken");
	a_ch3_guard: assert property (cmd_start && cmd_channel == 2'h3 && !two_adapters &&
		!$past(two_adapters) && !$past(two_adapters, 2) && !$past(two_adapters, 3)
		|=> cmd_refused) else $error("channel 3 start without adapters");
	a_busy_rise: assert property ($rose(busy_flag[2]) |->
		$past(cmd_start, 2) && $past(cmd_channel, 2) == 2'h2) else $error("busy rose uncommanded");
	a_busy_pulse: assert property ($changed(pulse_out[2]) |->
		busy_flag[2] || $past(busy_flag[2])) else $error("pulse while idle");
	a_stop_fast: assert property (stop_cmd[2] [*3] ##0 busy_flag[2] |->
		##[1:6] !busy_flag[2]) else $error("stop flag slow");
	a_decel_tail: assert property ($fell(cmd_active[1]) && busy_flag[1] && !stop_cmd[1]
		|=> busy_flag[1] [*8]) else $error("normal stop without tail");
	a_servo_off: assert property (servo_on && !cmd_start |-> ##[1:3] !servo_on)
		else $error("servo left on");
	a_fetch_once: assert property (fetched_reg |-> !servo_pos_req)
		else $error("second position fetch");
	c_refused: cover property (cmd_refused);
	c_servo_off: cover property ($fell(servo_on));
	c_stop: cover property (stop_cmd[2] && busy_flag[2]);
endmodule
bind pcag_top pcag_top_checker u_chk (.clk_sys, .nrst, .cmd_start, .cmd_code, .cmd_channel,
	.cmd_active, .stop_cmd, .two_adapters, .pulse_out, .busy_flag, .cmd_refused,
	.servo_on, .servo_pos_req);

// >>> sim/pulse_channel_activation_guard_bench.sv
// Purpose: self-checking bench for pcag_top
// Assumes: 40 MHz clock, servo model at the far side
// Notes:   small counts keep pulse trains short
`timescale 1ns/10ps
`include "pcag_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch %0t %h vs %h", $time, a, b); end end
module pulse_channel_activation_guard_bench;
	logic        clk_sys, nrst, cmd_start, cmd_dir, two_adapters, reg_wr, reg_rd;
	logic [3:0]  cmd_code, reg_addr, cmd_active, limit_fwd, limit_rev, stop_cmd;
	logic [1:0]  cmd_channel;
	logic [31:0] cmd_count, reg_wdata, reg_rdata, servo_pos_data, abs_val;
	logic        servo_pos_valid, cmd_refused, servo_on, servo_pos_req;
	logic [3:0]  pulse_out, dir_out, busy_flag;
	integer      err_count, checks_done, cycles, seed, fetches, k, n, exp_legacy, rises;
	pcag_top uut (.clk_sys, .nrst, .cmd_start, .cmd_code, .cmd_channel, .cmd_count,
		.cmd_dir, .cmd_active, .limit_fwd, .limit_rev, .stop_cmd, .two_adapters,
		.servo_pos_valid, .servo_pos_data, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .pulse_out, .dir_out, .busy_flag, .cmd_refused, .servo_on,
		.servo_pos_req);
	pcag_servo_model u_servo (.clk_sys, .servo_on, .servo_pos_req, .value(abs_val),
		.servo_pos_valid, .servo_pos_data, .fetches);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Hang guard, ceiling well above the longest tail
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			close_out;
		end
	end
	// Pulse rises on channel 1, counted at the pin
	always @(posedge pulse_out[1])
		rises++;
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rd(input [3:0] a, input [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	task automatic go(input [3:0] c, input [1:0] ch, input [31:0] cnt, input d, input r);
		@(posedge clk_sys);
		cmd_start <= 1'b1;
		cmd_code <= c;
		cmd_channel <= ch;
		cmd_count <= cnt;
		cmd_dir <= d;
		@(posedge clk_sys);
		cmd_start <= 1'b0;
		#1 `CHK(cmd_refused, r)
		@(posedge clk_sys);
		#1 if (!r) `CHK(busy_flag[ch], 1'b1)
	endtask
	task automatic idle(input [1:0] ch);
		while (busy_flag[ch] !== 1'b0)
			@(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic halt(input [1:0] ch);
		@(posedge clk_sys);
		stop_cmd[ch] <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1 `CHK(busy_flag[ch], 1'b0)
		@(posedge clk_sys);
		stop_cmd[ch] <= 1'b0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		seed = 32'hcdda;
		err_count = 0;
		checks_done = 0;
		cycles = 0;
		exp_legacy = 0;
		rises = 0;
		nrst = 1'b0;
		{cmd_start, cmd_dir, two_adapters, reg_wr, reg_rd} = 5'h00;
		{cmd_code, reg_addr, limit_fwd, limit_rev, stop_cmd} = 20'h00000;
		cmd_active = 4'hF;
		cmd_channel = 2'h0;
		cmd_count = 32'h0;
		reg_wdata = 32'h0;
		abs_val = $random(seed);
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (k = 0; k < 16; k++)
			rd(k[3:0], 32'h0);
		@(posedge clk_sys);
		cmd_start <= 1'b1;
		cmd_code <= `PCAG_CMD_ABS_READOUT;
		repeat (30) @(posedge clk_sys);
		#1 `CHK(servo_on, 1'b1)
		`CHK(fetches, 1)
		rd(4'h7, abs_val);
		@(posedge clk_sys);
		cmd_start <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 `CHK(servo_on, 1'b0)
		for (k = 0; k < 16; k++) begin
			if (k == 3 || k == 8 || k == 9)
				continue;
			go(k[3:0], 2'h2, 32'h4, 1'b0, k > 9);
			if (k < 10) begin
				go(`PCAG_CMD_INCR_DRIVE, 2'h2, 32'h4, 1'b0, 1'b1);
				halt(2'h2);
				idle(2'h2);
			end
		end
		for (k = 0; k < 2; k++) begin
			n = 2 + ($random(seed) & 3);
			exp_legacy = n;
			go(k ? `PCAG_CMD_RAMPED : `PCAG_CMD_FIXED_COUNT, 2'h0, n, 1'b0, 1'b0);
			idle(2'h0);
		end
		rd(4'h4, exp_legacy);
		rd(4'h0, 32'h0);
		// Limit decelerates: three pulses outlast 2000 cycles only when slowed
		go(`PCAG_CMD_INCR_DRIVE, 2'h2, 32'h3, 1'b0, 1'b0);
		@(posedge clk_sys);
		limit_fwd[2] <= 1'b1;
		repeat (2000) @(posedge clk_sys);
		#1 `CHK(busy_flag[2], 1'b1)
		halt(2'h2);
		limit_fwd[2] <= 1'b0;
		idle(2'h2);
		n = 3 + ($random(seed) & 3);
		go(`PCAG_CMD_INCR_DRIVE, 2'h1, n, 1'b0, 1'b0);
		idle(2'h1);
		`CHK(rises, n)
		// Reversal emits only the commanded pulses, no extra backlash pulse
		go(`PCAG_CMD_INCR_DRIVE, 2'h1, 32'h3, 1'b1, 1'b0);
		`CHK(dir_out[1], 1'b1)
		idle(2'h1);
		`CHK(rises, n + 3)
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= 4'h1;
		reg_wdata <= $random(seed);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		rd(4'h1, n - 3);
		go(`PCAG_CMD_INCR_DRIVE, 2'h3, 32'h2, 1'b0, 1'b1);
		@(posedge clk_sys);
		two_adapters <= 1'b1;
		repeat (4) @(posedge clk_sys);
		go(`PCAG_CMD_INCR_DRIVE, 2'h3, 32'h2, 1'b0, 1'b0);
		idle(2'h3);
		rd(4'h3, 32'h2);
		go(`PCAG_CMD_INCR_DRIVE, 2'h1, 32'hC8, 1'b0, 1'b0);
		repeat (2000) @(posedge clk_sys);
		cmd_active[1] <= 1'b0;
		repeat (20) @(posedge clk_sys);
		#1 `CHK(busy_flag[1], 1'b1)
		idle(2'h1);
		close_out;
	end
endmodule
